// >>> logic/prst_proc.sv
// processor-side reset interface: requests, reset decode, last-reset record
// Function
// - distinguish core, chip and system resets
// - core reset clears only processor block units
// - reset halts execution, discards state immediately
// - requests alone never reset anything
// - external inputs synchronous to processor clock
// - external inputs held at least eight cycles
// - only core, core+chip, core+chip+system combinations
// - record type 01 core, 10 chip, 11 system
// - no inputs active keeps recorded type
// - power-up asserts all inputs sixteen cycles, type 11
// - core input resets whole processor block
// - chip input only marks type
// - system input marks type, resets jtag unit
// - test reset input resets jtag test logic
// - core request holds until two cycles after input
// - debug field 01 raises core request
// - watchdog action 01 plus timeout raises core request
// - generator may support fewer reset kinds
// - value 10 raises chip request, same tail
// - value 11 raises system request, same tail
// - test reset input is active low
`timescale 1ns/10ps
`default_nettype none
module prst_proc
    import prst_pkg::*;
#(
    parameter int POR_HOLD = PRST_POR_HOLD
) (
    // clock and power-up reset
    input wire logic clk,
    input wire logic rst_b,
    // link to external generator
    prst_if.proc lnk,
    // debug reset field write, one-cycle strobe
    input wire logic debug_reset_wr,
    input wire logic [1:0] debug_reset_field,
    // watchdog
    input wire logic [1:0] watchdog_reset_action_field,
    input wire logic watchdog_reset_event,
    // effects inside the processor block
    output logic core_logic_reset,
    output logic jtag_unit_reset,
    output logic jtag_test_reset,
    output logic [1:0] last_reset_type_field
);
    // the power-up counter is PRST_CNT_W wide, so longer holds would wrap
    if (POR_HOLD < PRST_POR_HOLD || POR_HOLD > (2 ** PRST_CNT_W) - 1) begin : g_bad_por_hold
        $error("prst_proc: POR_HOLD out of range");
    end

    // one request channel: idle, asking, or draining the tail after its input
    typedef enum logic [1:0] {
        PRST_CH_IDLE,
        PRST_CH_ASK,
        PRST_CH_DRAIN
    } prst_ch_state_t;

    logic [PRST_CNT_W-1:0] por_cnt;
    logic por_active;
    logic [2:0] req;
    logic [1:0] tail [3];
    prst_ch_state_t ch [3];
    prst_ch_state_t next_ch [3];
    logic [1:0] next_tail [3];

    // power-up logic forces all four inputs, user cannot change it
    wire core_eff = lnk.core_reset_in | por_active;
    wire chip_eff = lnk.chip_reset_in | por_active;
    wire sys_eff = lnk.system_reset_in | por_active;
    wire tst_eff = ~lnk.test_reset_n_in | por_active;
    wire [2:0] in_eff = {sys_eff, chip_eff, core_eff};

    // type decode: system over chip over core
    wire [1:0] type_now = sys_eff ? PRST_TYPE_SYS : chip_eff ? PRST_TYPE_CHIP :
                          core_eff ? PRST_TYPE_CORE : PRST_TYPE_NONE;

    // request trigger by selected value, index 0 core 1 chip 2 system
    // every input is an argument so the decode follows the strobes
    function automatic logic hit(input logic wr, input logic [1:0] field, input logic ev,
                                 input logic [1:0] action, input logic [1:0] want);
        hit = (wr && field == want) || (ev && action == want);
    endfunction
    wire [2:0] trig = {
        hit(debug_reset_wr, debug_reset_field, watchdog_reset_event, watchdog_reset_action_field, PRST_TYPE_SYS),
        hit(debug_reset_wr, debug_reset_field, watchdog_reset_event, watchdog_reset_action_field, PRST_TYPE_CHIP),
        hit(debug_reset_wr, debug_reset_field, watchdog_reset_event, watchdog_reset_action_field, PRST_TYPE_CORE)
    };

    // a trigger while the channel is busy is ignored
    function automatic prst_ch_state_t ch_step(input prst_ch_state_t cur, input logic start,
                                               input logic seen, input logic [1:0] left);
        ch_step = cur;
        case (cur)
            PRST_CH_IDLE: begin
                if (start) begin
                    ch_step = PRST_CH_ASK;
                end
            end
            PRST_CH_ASK: begin
                if (seen) begin
                    ch_step = PRST_CH_DRAIN;
                end
            end
            PRST_CH_DRAIN: begin
                if (left == 2'h0) begin
                    ch_step = PRST_CH_IDLE;
                end
            end
            default: ch_step = PRST_CH_IDLE;
        endcase
    endfunction

    // cycles still to wait once the input has been seen
    function automatic logic [1:0] tail_step(input prst_ch_state_t cur, input logic seen,
                                             input logic [1:0] left);
        tail_step = left;
        if (cur == PRST_CH_ASK && seen) begin
            tail_step = 2'(PRST_REQ_TAIL - 1);
        end else if (cur == PRST_CH_DRAIN && left != 2'h0) begin
            tail_step = left - 1'b1;
        end
    endfunction

    // hold cannot be shortened from outside, only lengthened by parameter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            por_cnt <= '0;
            por_active <= 1'b1;
        end else if (por_active) begin
            por_cnt <= por_cnt + 1'b1;
            if (por_cnt == PRST_CNT_W'(POR_HOLD - 1)) begin
                por_active <= 1'b0;
            end
        end
    end

    // each request stays up until two cycles after its input
    assign next_ch[0] = ch_step(ch[0], trig[0], in_eff[0], tail[0]);
    assign next_ch[1] = ch_step(ch[1], trig[1], in_eff[1], tail[1]);
    assign next_ch[2] = ch_step(ch[2], trig[2], in_eff[2], tail[2]);
    assign next_tail[0] = tail_step(ch[0], in_eff[0], tail[0]);
    assign next_tail[1] = tail_step(ch[1], in_eff[1], tail[1]);
    assign next_tail[2] = tail_step(ch[2], in_eff[2], tail[2]);

    // requests drive only outputs, never the block's own reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ch[0] <= PRST_CH_IDLE;
            tail[0] <= 2'h0;
            req[0] <= 1'b0;
        end else begin
            ch[0] <= next_ch[0];
            tail[0] <= next_tail[0];
            req[0] <= (next_ch[0] != PRST_CH_IDLE);
        end
    end

    // chip request channel
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ch[1] <= PRST_CH_IDLE;
            tail[1] <= 2'h0;
            req[1] <= 1'b0;
        end else begin
            ch[1] <= next_ch[1];
            tail[1] <= next_tail[1];
            req[1] <= (next_ch[1] != PRST_CH_IDLE);
        end
    end

    // system request channel
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ch[2] <= PRST_CH_IDLE;
            tail[2] <= 2'h0;
            req[2] <= 1'b0;
        end else begin
            ch[2] <= next_ch[2];
            tail[2] <= next_tail[2];
            req[2] <= (next_ch[2] != PRST_CH_IDLE);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_logic_reset <= 1'b1;
            jtag_unit_reset <= 1'b1;
            jtag_test_reset <= 1'b1;
            last_reset_type_field <= PRST_TYPE_NONE;
        end else begin
            // core input alone resets the block; chip input adds nothing
            core_logic_reset <= core_eff;
            jtag_unit_reset <= sys_eff;
            jtag_test_reset <= tst_eff;
            // power-up records as system since all inputs are forced
            if (type_now != PRST_TYPE_NONE) begin
                last_reset_type_field <= type_now;
            end
            // all inputs inactive keeps the old value
        end
    end

    assign lnk.core_reset_request = req[0];
    assign lnk.chip_reset_request = req[1];
    assign lnk.system_reset_request = req[2];
endmodule
`default_nettype wire

// >>> logic/prst_pkg.sv
// shared constants and types for the processor reset interface
package prst_pkg;
    // last-reset-type field encodings
    localparam logic [1:0] PRST_TYPE_NONE = 2'h0;
    localparam logic [1:0] PRST_TYPE_CORE = 2'h1;
    localparam logic [1:0] PRST_TYPE_CHIP = 2'h2;
    localparam logic [1:0] PRST_TYPE_SYS = 2'h3;
    // minimum reset input hold, in processor clock cycles
    localparam int PRST_MIN_HOLD = 8;
    // power-up hold of all reset inputs
    localparam int PRST_POR_HOLD = 16;
    // request stays up this many cycles after its input is seen
    localparam int PRST_REQ_TAIL = 2;
    localparam int PRST_CNT_W = 8;
    typedef enum logic [1:0] {
        PRST_IDLE,
        PRST_DRIVE,
        PRST_WAIT
    } prst_gen_state_t;
endpackage

// >>> logic/prst_if.sv
// link between the processor reset end and the external reset generator
`timescale 1ns/10ps
`default_nettype none
interface prst_if;
    logic core_reset_in;
    logic chip_reset_in;
    logic system_reset_in;
    logic test_reset_n_in;
    logic core_reset_request;
    logic chip_reset_request;
    logic system_reset_request;
    modport proc (
        input core_reset_in, chip_reset_in, system_reset_in, test_reset_n_in,
        output core_reset_request, chip_reset_request, system_reset_request
    );
    modport gen (
        output core_reset_in, chip_reset_in, system_reset_in, test_reset_n_in,
        input core_reset_request, chip_reset_request, system_reset_request
    );
endinterface
`default_nettype wire

// >>> logic/prst_gen.sv
// external reset generator: turns requests into reset input combinations
`timescale 1ns/10ps
`default_nettype none
module prst_gen
    import prst_pkg::*;
#(
    parameter int HOLD = PRST_MIN_HOLD
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link to processor end
    prst_if.gen lnk,
    // user side: board-level reset requests, one-cycle pulses
    input wire logic user_core_req,
    input wire logic user_chip_req,
    input wire logic user_sys_req,
    input wire logic user_test_req,
    // status
    output logic busy
);
    // the hold counter is PRST_CNT_W wide, so longer holds would wrap
    if (HOLD < PRST_MIN_HOLD || HOLD > (2 ** PRST_CNT_W) - 1) begin : g_bad_hold
        $error("prst_gen: HOLD out of range");
    end

    prst_gen_state_t state;
    logic [1:0] kind;
    logic test_kind;
    logic [PRST_CNT_W-1:0] cnt;
    logic c_in, h_in, s_in, t_n;

    // system beats chip beats core when several arrive together
    wire want_sys = lnk.system_reset_request | user_sys_req;
    wire want_chip = lnk.chip_reset_request | user_chip_req;
    wire want_core = lnk.core_reset_request | user_core_req;
    wire want_any = want_sys | want_chip | want_core | user_test_req;
    wire [1:0] pick = want_sys ? PRST_TYPE_SYS : want_chip ? PRST_TYPE_CHIP :
                      want_core ? PRST_TYPE_CORE : PRST_TYPE_NONE;
    wire hold_done = (cnt == PRST_CNT_W'(HOLD - 1));

    // only the three legal combinations are ever driven
    wire drv_core = (state == PRST_DRIVE) && (kind != PRST_TYPE_NONE);
    wire drv_chip = (state == PRST_DRIVE) && (kind == PRST_TYPE_CHIP || kind == PRST_TYPE_SYS);
    wire drv_sys = (state == PRST_DRIVE) && (kind == PRST_TYPE_SYS);
    wire drv_tst = (state == PRST_DRIVE) && test_kind;

    // latch request, hold, release together
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= PRST_IDLE;
            kind <= PRST_TYPE_NONE;
            test_kind <= 1'b0;
            cnt <= '0;
        end else begin
            case (state)
                PRST_IDLE: begin
                    if (want_any) begin
                        state <= PRST_DRIVE;
                        kind <= pick;
                        test_kind <= user_test_req & ~(want_sys | want_chip | want_core);
                        cnt <= '0;
                    end
                end
                PRST_DRIVE: begin
                    cnt <= cnt + 1'b1;
                    if (hold_done) begin
                        state <= PRST_WAIT;
                    end
                end
                // let the request tail drain before looking again
                PRST_WAIT: begin
                    if (!(lnk.system_reset_request | lnk.chip_reset_request | lnk.core_reset_request)) begin
                        state <= PRST_IDLE;
                    end
                end
                default: state <= PRST_IDLE;
            endcase
        end
    end

    // registered outputs, synchronous to clk
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            c_in <= 1'b0;
            h_in <= 1'b0;
            s_in <= 1'b0;
            t_n <= 1'b1;
            busy <= 1'b0;
        end else begin
            c_in <= drv_core;
            h_in <= drv_chip;
            s_in <= drv_sys;
            t_n <= ~drv_tst;
            busy <= (state != PRST_IDLE) || want_any;
        end
    end

    assign lnk.core_reset_in = c_in;
    assign lnk.chip_reset_in = h_in;
    assign lnk.system_reset_in = s_in;
    assign lnk.test_reset_n_in = t_n;
endmodule
`default_nettype wire

// >>> tb/prst_monitor.sv
// link checks between reset generator and processor end
`timescale 1ns/10ps
`default_nettype none
module prst_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic core_reset_in,
    input wire logic chip_reset_in,
    input wire logic system_reset_in,
    input wire logic test_reset_n_in,
    input wire logic core_reset_request,
    input wire logic chip_reset_request,
    input wire logic system_reset_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_legal_combo: assert property ((chip_reset_in |-> core_reset_in) and (system_reset_in |-> chip_reset_in))
        else $error("illegal input combination");
    a_min_hold: assert property ($rose(core_reset_in) |-> core_reset_in [*8])
        else $error("reset input held too briefly");
    a_release_together: assert property ($fell(core_reset_in) |-> !chip_reset_in && !system_reset_in)
        else $error("inputs not released together");
    a_core_req_tail: assert property ($rose(core_reset_in) && core_reset_request |-> core_reset_request [*2] ##[1:2] !core_reset_request)
        else $error("core request tail wrong");
    a_chip_req_tail: assert property ($rose(chip_reset_in) && chip_reset_request |-> chip_reset_request [*2] ##[1:2] !chip_reset_request)
        else $error("chip request tail wrong");
    a_sys_req_tail: assert property ($rose(system_reset_in) && system_reset_request |-> system_reset_request [*2] ##[1:2] !system_reset_request)
        else $error("system request tail wrong");
    a_gen_answer: assert property ($rose(core_reset_request) |-> ##[1:3] core_reset_in)
        else $error("generator did not answer");
    a_test_idle: assert property (core_reset_in |-> test_reset_n_in)
        else $error("test reset active with core reset");
    // scenario reach
    cover property (system_reset_in);
    cover property ($rose(core_reset_request));
    cover property (!test_reset_n_in);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// bench: generator and processor end joined over the reset link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import prst_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic debug_reset_wr = 1'b0;
    logic [1:0] debug_reset_field = 2'h0;
    logic [1:0] watchdog_reset_action_field = 2'h0;
    logic watchdog_reset_event = 1'b0;
    logic user_core_req = 1'b0, user_chip_req = 1'b0, user_sys_req = 1'b0, user_test_req = 1'b0;
    logic busy, core_logic_reset, jtag_unit_reset, jtag_test_reset;
    logic [1:0] last_reset_type_field;
    logic saw_core, saw_jtag, saw_test;
    int n_errors = 0;
    int samples_checked = 0;
    prst_if lnk ();
    prst_gen prst_gen_i (.clk(clk), .rst_b(rst_b), .lnk(lnk), .user_core_req(user_core_req),
        .user_chip_req(user_chip_req), .user_sys_req(user_sys_req), .user_test_req(user_test_req), .busy(busy));
    prst_proc prst_proc_i (.clk(clk), .rst_b(rst_b), .lnk(lnk), .debug_reset_wr(debug_reset_wr),
        .debug_reset_field(debug_reset_field), .watchdog_reset_action_field(watchdog_reset_action_field),
        .watchdog_reset_event(watchdog_reset_event), .core_logic_reset(core_logic_reset),
        .jtag_unit_reset(jtag_unit_reset), .jtag_test_reset(jtag_test_reset),
        .last_reset_type_field(last_reset_type_field));
    prst_monitor prst_monitor_i (.clk(clk), .rst_b(rst_b), .core_reset_in(lnk.core_reset_in),
        .chip_reset_in(lnk.chip_reset_in), .system_reset_in(lnk.system_reset_in),
        .test_reset_n_in(lnk.test_reset_n_in), .core_reset_request(lnk.core_reset_request),
        .chip_reset_request(lnk.chip_reset_request), .system_reset_request(lnk.system_reset_request));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // waits for the whole exchange to end, noting which effects showed up
    task automatic settle();
        saw_core = 1'b0;
        saw_jtag = 1'b0;
        saw_test = 1'b0;
        for (int i = 0; i < 80; i++) begin
            @(negedge clk);
            saw_core |= core_logic_reset;
            saw_jtag |= jtag_unit_reset;
            saw_test |= jtag_test_reset;
            if (i > 4 && {busy, core_logic_reset, jtag_unit_reset, jtag_test_reset} === 4'h0
                && {lnk.core_reset_request, lnk.chip_reset_request, lnk.system_reset_request} === 3'h0) return;
        end
        cmp(3'h7, 3'h0);
        test_done();
    endtask
    // one trigger from debug field or watchdog, judged end to end
    task automatic trig(input logic wd, input logic [1:0] val);
        logic [1:0] prev;
        prev = last_reset_type_field;
        @(posedge clk);
        debug_reset_field <= val;
        watchdog_reset_action_field <= val;
        debug_reset_wr <= !wd;
        watchdog_reset_event <= wd;
        @(posedge clk);
        debug_reset_wr <= 1'b0;
        watchdog_reset_event <= 1'b0;
        @(negedge clk);
        cmp({lnk.system_reset_request, lnk.chip_reset_request, lnk.core_reset_request},
            (val == 2'h0) ? 3'h0 : 3'h1 << (val - 2'h1));
        cmp({2'h0, core_logic_reset}, 3'h0);
        settle();
        cmp({1'b0, last_reset_type_field}, {1'b0, (val == 2'h0) ? prev : val});
        cmp({2'h0, saw_core}, {2'h0, val != 2'h0});
        cmp({2'h0, saw_jtag}, {2'h0, val == PRST_TYPE_SYS});
    endtask
    task automatic t_por();
        int n;
        n = 0;
        @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        while (core_logic_reset === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        cmp({2'h0, n >= PRST_POR_HOLD}, 3'h1);
        settle();
        cmp({1'b0, last_reset_type_field}, {1'b0, PRST_TYPE_SYS});
    endtask
    task automatic t_watchdog();
        for (int v = 1; v < 4; v++) trig(1'b1, v[1:0]);
    endtask
    task automatic t_debug();
        for (int v = 1; v < 4; v++) trig(1'b0, v[1:0]);
    endtask
    // value 00 from either source must change nothing
    task automatic t_idle();
        trig(1'b0, 2'h0);
        trig(1'b1, 2'h0);
    endtask
    task automatic t_board();
        logic [1:0] prev;
        @(posedge clk);
        user_core_req <= 1'b1;
        @(posedge clk);
        user_core_req <= 1'b0;
        settle();
        cmp({1'b0, last_reset_type_field}, {1'b0, PRST_TYPE_CORE});
        cmp({2'h0, saw_jtag}, 3'h0);
        prev = last_reset_type_field;
        @(posedge clk);
        user_test_req <= 1'b1;
        @(posedge clk);
        user_test_req <= 1'b0;
        settle();
        cmp({1'b0, saw_core, saw_test}, 3'h1);
        cmp({1'b0, last_reset_type_field}, {1'b0, prev});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        t_por();
        t_watchdog();
        t_board();
        t_debug();
        t_idle();
        test_done();
    end
endmodule
`default_nettype wire
